// ### design/aucr_consts.svh
// Constants for the upper configuration register bank: offsets, fields,
// reset values. Assumes a 13-bit register address from the serial port.
`ifndef AUCR_CONSTS_SVH
`define AUCR_CONSTS_SVH
`define AUCR_ADDR_W 13
`define AUCR_OFF_CHSEL_A 13'h0004
`define AUCR_OFF_CHSEL_B 13'h0005
`define AUCR_OFF_PAT1_LO 13'h0019
`define AUCR_OFF_PAT1_HI 13'h001A
`define AUCR_OFF_PAT2_LO 13'h001B
`define AUCR_OFF_PAT2_HI 13'h001C
`define AUCR_OFF_SER_FMT 13'h0021
`define AUCR_OFF_CH_PWR 13'h0022
`define AUCR_OFF_XFER 13'h00FF
`define AUCR_OFF_RATE_OVR 13'h0100
`define AUCR_OFF_IO_CTL2 13'h0101
`define AUCR_OFF_IO_CTL3 13'h0102
`define AUCR_OFF_SYNC 13'h0109
`define AUCR_RST_ZERO 8'h00
`define AUCR_RST_CHSEL 8'h3F
`define AUCR_RST_SER_FMT 8'h30
`define AUCR_FMT_LSB_FIRST 7
`define AUCR_FMT_MODE_HI 6
`define AUCR_FMT_MODE_LO 4
`define AUCR_FMT_FRAME_X2 2
`define AUCR_FMT_BITS_X2 1
`define AUCR_CHP_PDWN 0
`define AUCR_CHP_ORST 1
`define AUCR_OVR_EN 6
`define AUCR_OVR_RATE_HI 2
`define AUCR_OVR_RATE_LO 0
`define AUCR_XFER_BIT 0
`define AUCR_IO2_PULLDN 0
`define AUCR_IO3_CM_PDWN 3
`define AUCR_SYNC_EN 0
`define AUCR_SYNC_NEXT 1
`define AUCR_CH_N 4
`define AUCR_CLK_CH_N 2
`endif

// ### design/aucr_pkg.sv
// Types for the upper configuration register bank.
// Assumes nothing of its surroundings.
package aucr_pkg;
  typedef enum logic [2:0] {
    AUCR_SDR_2L_BIT,
    AUCR_SDR_2L_BYTE,
    AUCR_DDR_2L_BIT,
    AUCR_DDR_2L_BYTE,
    AUCR_DDR_1L_WORD,
    AUCR_MODE_RSVD
  } aucr_ser_mode_t;
  typedef enum logic {
    AUCR_SYNC_IDLE,
    AUCR_SYNC_DONE
  } aucr_sync_state_t;
endpackage

// ### design/aucr_sync_gate.sv
// Multichip sync gate: passes sync events while armed, optionally once.
// Assumes sync_evt_in is a one-cycle pulse already on clock_in.
`timescale 1ns/10ps
`include "aucr_consts.svh"
module aucr_sync_gate (
  input wire logic clock_in,   // Serial-port clock
  input wire logic srst_in,    // Sync reset, active high
  input wire logic arm_in,     // Sync enable bit
  input wire logic next_in,    // Honour next event only
  input wire logic rearm_in,   // Sync register written
  input wire logic sync_evt_in, // Incoming sync event pulse
  output logic sync_out        // Honoured sync pulse
);
  aucr_pkg::aucr_sync_state_t state_r;
  logic pass;
  assign pass = arm_in && sync_evt_in &&
    !(next_in && state_r == aucr_pkg::AUCR_SYNC_DONE);
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_r <= aucr_pkg::AUCR_SYNC_IDLE;
    end else if (pass && next_in) begin
      // A sync taken in the cycle of a rewrite still uses up the shot
      state_r <= aucr_pkg::AUCR_SYNC_DONE;
    end else if (rearm_in || !arm_in) begin
      state_r <= aucr_pkg::AUCR_SYNC_IDLE;
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= pass;
    end
  end
endmodule

// ### design/aucr_regs.sv
// Upper configuration register bank of a four-channel converter.
// Assumes a serial-port front end that delivers single-cycle write and
// read strobes with an address and byte, all on clock_in.
`timescale 1ns/10ps
`include "aucr_consts.svh"
module aucr_regs #(
  parameter int CH_N = `AUCR_CH_N,
  parameter int CLK_CH_N = `AUCR_CLK_CH_N
) (
  input wire logic clock_in,               // Serial-port clock
  input wire logic srst_in,                // Sync reset, active high
  input wire logic wr_en_in,               // Register write strobe
  input wire logic rd_en_in,               // Register read strobe
  input wire logic [12:0] addr_in,         // Register address
  input wire logic [7:0] wdata_in,         // Write data
  input wire logic sync_evt_in,            // Sync event pulse
  output logic [7:0] rdata_out,            // Read data
  output logic rvalid_out,                 // Read data valid
  output logic [15:0] pattern_one_out,     // User pattern one
  output logic [15:0] pattern_two_out,     // User pattern two
  output logic [2:0] ser_mode_out,         // Serialization mode code
  output logic two_lane_out,               // Two-lane mode active
  output logic ddr_out,                    // Double data rate active
  output logic bytewise_out,               // Bytewise or wordwise packing
  output logic lsb_first_out,              // LSB-first stream
  output logic frame_x2_out,               // Doubled frame period
  output logic bits_x2_out,                // Doubled bits per sample
  output logic [CH_N-1:0] ch_pdwn_out,     // Per-channel power-down
  output logic [CH_N-1:0] ch_orst_out,     // Per-channel output reset
  output logic [CLK_CH_N-1:0] clk_pdwn_out, // Clock output power-down
  output logic rate_ovr_en_out,            // Applied override enable
  output logic [2:0] rate_cap_out,         // Applied rate cap code
  output logic sdio_pulldn_dis_out,        // SDIO pull-down disable
  output logic cm_buf_pdwn_out,            // common_mode_output power-down
  output logic sync_out                    // Honoured sync pulse
);
  logic [7:0] chsel_a_r;
  logic [7:0] chsel_b_r;
  logic [7:0] pat1_lo_r;
  logic [7:0] pat1_hi_r;
  logic [7:0] pat2_lo_r;
  logic [7:0] pat2_hi_r;
  logic [7:0] ser_fmt_r;
  logic [7:0] ovr_shadow_r;
  logic [7:0] ovr_live_r;
  logic [7:0] io2_r;
  logic [7:0] io3_r;
  logic [7:0] sync_r;
  logic [CH_N-1:0] pdwn_r;
  logic [CH_N-1:0] orst_r;
  logic [CLK_CH_N-1:0] clk_pdwn_r;
  logic [7:0] rdata_nxt;
  logic [2:0] mode;
  logic [2:0] lane_r;
  localparam logic [7:0] FMT_RST = `AUCR_RST_SER_FMT;

  // One address match shared by every register write
  function automatic logic wr_hit(input logic [12:0] a);
    wr_hit = wr_en_in && (addr_in == a);
  endfunction

  // data channel index
  // Reset selects every channel, so early local writes reach all
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      chsel_a_r <= `AUCR_RST_CHSEL;
    end else if (wr_hit(`AUCR_OFF_CHSEL_A)) begin
      chsel_a_r <= wdata_in;
    end
  end

  // data bits assumed equal to the other index
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      chsel_b_r <= `AUCR_RST_CHSEL;
    end else if (wr_hit(`AUCR_OFF_CHSEL_B)) begin
      chsel_b_r <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pat1_lo_r <= `AUCR_RST_ZERO;
      pat1_hi_r <= `AUCR_RST_ZERO;
    end else begin
      if (wr_hit(`AUCR_OFF_PAT1_LO)) begin
        pat1_lo_r <= wdata_in;
      end
      if (wr_hit(`AUCR_OFF_PAT1_HI)) begin
        pat1_hi_r <= wdata_in;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pat2_lo_r <= `AUCR_RST_ZERO;
      pat2_hi_r <= `AUCR_RST_ZERO;
    end else begin
      if (wr_hit(`AUCR_OFF_PAT2_LO)) begin
        pat2_lo_r <= wdata_in;
      end
      if (wr_hit(`AUCR_OFF_PAT2_HI)) begin
        pat2_hi_r <= wdata_in;
      end
    end
  end

  // format register, reset MSB first
  // Bit 3 is open and reads back zero
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ser_fmt_r <= `AUCR_RST_SER_FMT;
    end else if (wr_hit(`AUCR_OFF_SER_FMT)) begin
      ser_fmt_r <= wdata_in & 8'hF7;
    end
  end

  // SDR two-lane codes 000 and 001
  // DDR two-lane 010, 011; one-lane 100
  // Reserved codes fall back to two-lane SDR bitwise
  function automatic logic [2:0] mode_flags(input logic [2:0] code);
    logic is_ddr;
    logic one_lane;
    logic packs;
    is_ddr = (code == aucr_pkg::AUCR_DDR_2L_BIT) ||
      (code == aucr_pkg::AUCR_DDR_2L_BYTE) ||
      (code == aucr_pkg::AUCR_DDR_1L_WORD);
    one_lane = (code == aucr_pkg::AUCR_DDR_1L_WORD);
    packs = (code == aucr_pkg::AUCR_SDR_2L_BYTE) ||
      (code == aucr_pkg::AUCR_DDR_2L_BYTE) ||
      (code == aucr_pkg::AUCR_DDR_1L_WORD);
    mode_flags = {is_ddr, !one_lane, packs};
  endfunction

  // Flags load on the same edge as the format byte, so they never lag it
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lane_r <= mode_flags(FMT_RST[`AUCR_FMT_MODE_HI:`AUCR_FMT_MODE_LO]);
    end else if (wr_hit(`AUCR_OFF_SER_FMT)) begin
      lane_r <= mode_flags(wdata_in[`AUCR_FMT_MODE_HI:`AUCR_FMT_MODE_LO]);
    end
  end

  // local bits land only on selected channels
  // power-down and output reset per channel
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pdwn_r <= '0;
      orst_r <= '0;
    end else if (wr_hit(`AUCR_OFF_CH_PWR)) begin
      for (int i = 0; i < CH_N; i++) begin
        if (chsel_a_r[i]) begin
          pdwn_r[i] <= wdata_in[`AUCR_CHP_PDWN];
          orst_r[i] <= wdata_in[`AUCR_CHP_ORST];
        end
      end
    end
  end

  // clock outputs take only power-down
  // Clock outputs have no output reset to drive
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      clk_pdwn_r <= '0;
    end else if (wr_hit(`AUCR_OFF_CH_PWR)) begin
      for (int i = 0; i < CLK_CH_N; i++) begin
        if (chsel_b_r[CH_N+i]) begin
          clk_pdwn_r[i] <= wdata_in[`AUCR_CHP_PDWN];
        end
      end
    end
  end

  // override shadow, fixed-zero bits masked
  // Rate code 111 is kept as written; only codes up to 110 are defined
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ovr_shadow_r <= `AUCR_RST_ZERO;
    end else if (wr_hit(`AUCR_OFF_RATE_OVR)) begin
      ovr_shadow_r <= wdata_in & 8'h47;
    end
  end

  // shadow applied on transfer strobe
  // Transfer reads as zero: it is a self-clearing command
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ovr_live_r <= `AUCR_RST_ZERO;
    end else if (wr_hit(`AUCR_OFF_XFER) && wdata_in[`AUCR_XFER_BIT]) begin
      ovr_live_r <= ovr_shadow_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      io2_r <= `AUCR_RST_ZERO;
      io3_r <= `AUCR_RST_ZERO;
      sync_r <= `AUCR_RST_ZERO;
    end else begin
      // Open bits are masked so they always read back zero
      if (wr_hit(`AUCR_OFF_IO_CTL2)) begin
        io2_r <= wdata_in & 8'h01;
      end
      if (wr_hit(`AUCR_OFF_IO_CTL3)) begin
        io3_r <= wdata_in & 8'h08;
      end
      if (wr_hit(`AUCR_OFF_SYNC)) begin
        sync_r <= wdata_in & 8'h03;
      end
    end
  end

  // Local register reads the first selected channel
  // With several channels selected, the others stay hidden
  function automatic logic [7:0] local_rd();
    logic [7:0] v;
    v = 8'h00;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (chsel_a_r[i]) begin
        v = {6'h00, orst_r[i], pdwn_r[i]};
      end
    end
    local_rd = v;
  endfunction

  always_comb begin
    unique case (addr_in)
      `AUCR_OFF_CHSEL_A: rdata_nxt = chsel_a_r;
      `AUCR_OFF_CHSEL_B: rdata_nxt = chsel_b_r;
      `AUCR_OFF_PAT1_LO: rdata_nxt = pat1_lo_r;
      `AUCR_OFF_PAT1_HI: rdata_nxt = pat1_hi_r;
      `AUCR_OFF_PAT2_LO: rdata_nxt = pat2_lo_r;
      `AUCR_OFF_PAT2_HI: rdata_nxt = pat2_hi_r;
      `AUCR_OFF_SER_FMT: rdata_nxt = ser_fmt_r;
      `AUCR_OFF_CH_PWR: rdata_nxt = local_rd();
      `AUCR_OFF_RATE_OVR: rdata_nxt = ovr_shadow_r;
      `AUCR_OFF_IO_CTL2: rdata_nxt = io2_r;
      `AUCR_OFF_IO_CTL3: rdata_nxt = io3_r;
      `AUCR_OFF_SYNC: rdata_nxt = sync_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      // Read data holds between reads so the host may fetch it late
      if (rd_en_in) begin
        rdata_out <= rdata_nxt;
      end
    end
  end

  assign mode = ser_fmt_r[`AUCR_FMT_MODE_HI:`AUCR_FMT_MODE_LO];
  assign pattern_one_out = {pat1_hi_r, pat1_lo_r};
  assign pattern_two_out = {pat2_hi_r, pat2_lo_r};
  assign ser_mode_out = mode;
  assign ddr_out = lane_r[2];
  assign two_lane_out = lane_r[1];
  assign bytewise_out = lane_r[0];
  assign lsb_first_out = ser_fmt_r[`AUCR_FMT_LSB_FIRST];
  assign frame_x2_out = ser_fmt_r[`AUCR_FMT_FRAME_X2];
  assign bits_x2_out = ser_fmt_r[`AUCR_FMT_BITS_X2];
  assign ch_pdwn_out = pdwn_r;
  assign ch_orst_out = orst_r;
  assign clk_pdwn_out = clk_pdwn_r;
  assign rate_ovr_en_out = ovr_live_r[`AUCR_OVR_EN];
  assign rate_cap_out = ovr_live_r[`AUCR_OVR_RATE_HI:`AUCR_OVR_RATE_LO];
  assign sdio_pulldn_dis_out = io2_r[`AUCR_IO2_PULLDN];
  assign cm_buf_pdwn_out = io3_r[`AUCR_IO3_CM_PDWN];

  // sync arming
  // Rewriting the sync register rearms the one-shot unless the shot is taken in that cycle
  aucr_sync_gate u_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .arm_in(sync_r[`AUCR_SYNC_EN]),
    .next_in(sync_r[`AUCR_SYNC_NEXT]),
    .rearm_in(wr_hit(`AUCR_OFF_SYNC)),
    .sync_evt_in(sync_evt_in),
    .sync_out(sync_out)
  );
endmodule

// ### tb/aucr_props.sv
// Port checker for the upper configuration register bank.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module aucr_props (
  input wire logic clock_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic wr_en_in, // Write
  input wire logic [12:0] addr_in, // Address
  input wire logic [7:0] wdata_in, // Byte
  input wire logic sync_evt_in, // Sync in
  input wire logic [15:0] pattern_one_out, // Pattern one
  input wire logic [15:0] pattern_two_out, // Pattern two
  input wire logic [2:0] ser_mode_out, // Mode
  input wire logic two_lane_out, // Lanes
  input wire logic ddr_out, // Rate
  input wire logic bytewise_out, // Packing
  input wire logic lsb_first_out, // Order
  input wire logic frame_x2_out, // Frame x2
  input wire logic bits_x2_out, // Bits x2
  input wire logic rate_ovr_en_out, // Override on
  input wire logic [2:0] rate_cap_out, // Rate cap
  input wire logic sync_out // Sync out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  property p_pat1;
    wr_en_in && addr_in == 13'h0019 |=> pattern_one_out[7:0] == $past(wdata_in);
  endproperty
  a_pat1: assert property (p_pat1) else $error("pattern one low");
  property p_pat2;
    wr_en_in && addr_in == 13'h001C |=> pattern_two_out[15:8] == $past(wdata_in);
  endproperty
  a_pat2: assert property (p_pat2) else $error("pattern two high");
  property p_sdr;
    ser_mode_out[2:1] == 2'h0 |->
      !ddr_out && two_lane_out && bytewise_out == ser_mode_out[0];
  endproperty
  a_sdr: assert property (p_sdr) else $error("single rate decode");
  property p_ddr2;
    ser_mode_out[2:1] == 2'h1 |->
      ddr_out && two_lane_out && bytewise_out == ser_mode_out[0];
  endproperty
  a_ddr2: assert property (p_ddr2) else $error("two lane ddr");
  property p_ddr1;
    ser_mode_out == 3'h4 |-> ddr_out && !two_lane_out && bytewise_out;
  endproperty
  a_ddr1: assert property (p_ddr1) else $error("one lane ddr");
  property p_fmt;
    wr_en_in && addr_in == 13'h0021 |=>
      {lsb_first_out, ser_mode_out} == $past(wdata_in[7:4]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format bits");
  property p_dbl;
    wr_en_in && addr_in == 13'h0021 |=>
      {frame_x2_out, bits_x2_out} == $past(wdata_in[2:1]);
  endproperty
  a_dbl: assert property (p_dbl) else $error("doubling bits");
  // Applied override moves only after a transfer strobe
  property p_ovr;
    !$past(wr_en_in && addr_in == 13'h00FF && wdata_in[0]) |->
      $stable({rate_ovr_en_out, rate_cap_out});
  endproperty
  a_ovr: assert property (p_ovr) else $error("override moved");
  property p_sync;
    sync_out |-> $past(sync_evt_in);
  endproperty
  a_sync: assert property (p_sync) else $error("sync without event");
endmodule
bind aucr_regs aucr_props u_props (.clock_in, .srst_in, .wr_en_in,
  .addr_in, .wdata_in, .sync_evt_in, .pattern_one_out, .pattern_two_out,
  .ser_mode_out, .two_lane_out, .ddr_out, .bytewise_out, .lsb_first_out,
  .frame_x2_out, .bits_x2_out, .rate_ovr_en_out, .rate_cap_out, .sync_out);

// ### tb/aucr_host.sv
// Serial-port host model issuing single-cycle register strobes.
// Assumes the bank samples on the rising edge of clock_in.
`timescale 1ns/10ps
module aucr_host (
  input wire logic clock_in, // Clock
  input wire logic [7:0] rdata_in, // Read byte
  input wire logic rvalid_in, // Read valid
  output logic wr_en_out, // Write strobe
  output logic rd_en_out, // Read strobe
  output logic [12:0] addr_out, // Address
  output logic [7:0] wdata_out // Write byte
);
  initial {wr_en_out, rd_en_out, addr_out, wdata_out} = '0;
  // Idle bus shows inverted junk, never the last value
  task automatic xfer(input logic wr, input logic [12:0] a,
    input logic [7:0] d, output logic [8:0] q);
    @(negedge clock_in);
    addr_out = a;
    wdata_out = d;
    wr_en_out = wr;
    rd_en_out = ~wr;
    @(negedge clock_in);
    q = {rvalid_in, rdata_in};
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// ### tb/test_adc_upper_config_registers.sv
// Self-checking bench for the upper configuration register bank.
// Assumes the host model and one 250 MHz clock.
`timescale 1ns/10ps
module test_adc_upper_config_registers;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic sync_evt_in = 1'b0;
  logic wr_en, rd_en, rvalid, tl, ddr, bw, lsb, fx2, bx2, oen, pd, cm, so;
  logic [12:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] p1, p2;
  logic [2:0] mode, cap;
  logic [3:0] pdw, ors, mp, mo, ov;
  logic [1:0] cpd, mc;
  logic [7:0] m [512];
  logic [12:0] al [14] = '{13'h004, 13'h005, 13'h019, 13'h01A, 13'h01B,
    13'h01C, 13'h021, 13'h022, 13'h0FF, 13'h100, 13'h101, 13'h102,
    13'h109, 13'h1FF};
  int err_count = 0;
  int cmp_count = 0;
  int seed = 87619;
  always #2 clock_in = ~clock_in;
  aucr_regs dut (.clock_in, .srst_in, .wr_en_in(wr_en), .rd_en_in(rd_en),
    .addr_in(addr), .wdata_in(wdata), .sync_evt_in, .rdata_out(rdata),
    .rvalid_out(rvalid), .pattern_one_out(p1), .pattern_two_out(p2),
    .ser_mode_out(mode), .two_lane_out(tl), .ddr_out(ddr),
    .bytewise_out(bw), .lsb_first_out(lsb), .frame_x2_out(fx2),
    .bits_x2_out(bx2), .ch_pdwn_out(pdw), .ch_orst_out(ors),
    .clk_pdwn_out(cpd), .rate_ovr_en_out(oen), .rate_cap_out(cap),
    .sdio_pulldn_dis_out(pd), .cm_buf_pdwn_out(cm), .sync_out(so));
  aucr_host host (.clock_in, .rdata_in(rdata), .rvalid_in(rvalid),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wdata_out(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [2:0] dec(input logic [2:0] c);
    if (c == 3'h4) return 3'h5;
    if (c > 3'h4) return 3'h2;
    return {c[1], 1'b1, c[0]};
  endfunction
  function automatic logic [7:0] msk(input logic [12:0] a);
    case (a)
      13'h004, 13'h005, 13'h019, 13'h01A, 13'h01B, 13'h01C: return 8'hFF;
      13'h021: return 8'hF7;
      13'h100: return 8'h47;
      13'h101: return 8'h01;
      13'h102: return 8'h08;
      13'h109: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction
  // Local register reads back the lowest selected channel
  function automatic logic [8:0] er(input logic [12:0] a);
    er = {1'b1, m[a]};
    if (a == 13'h022) begin
      er = 9'h100;
      for (int i = 3; i >= 0; i--)
        if (m[4][i]) er = {7'h40, mo[i], mp[i]};
    end
  endfunction
  task automatic w(input logic [12:0] a, input logic [7:0] d);
    logic [8:0] q;
    host.xfer(1'b1, a, d, q);
    if (a == 13'h022) begin
      for (int i = 0; i < 4; i++) if (m[4][i]) {mo[i], mp[i]} = d[1:0];
      for (int j = 0; j < 2; j++) if (m[5][4+j]) mc[j] = d[0];
    end
    else if (a == 13'h0FF && d[0]) ov = {m[256][6], m[256][2:0]};
    else m[a] = d & msk(a);
  endtask
  task automatic chk_out();
    chk(p1, {m[26], m[25]});
    chk(p2, {m[28], m[27]});
    chk({mode, ddr, tl, bw}, {m[33][6:4], dec(m[33][6:4])});
    chk({lsb, fx2, bx2}, {m[33][7], m[33][2:1]});
    chk({ors, pdw, cpd}, {mo, mp, mc});
    chk({oen, cap}, ov);
    chk({pd, cm}, {m[257][0], m[258][3]});
  endtask
  task automatic rdall();
    logic [8:0] q;
    foreach (al[k]) begin
      host.xfer(1'b0, al[k], 8'h00, q);
      chk(q, er(al[k]));
    end
    chk_out();
  endtask
  task automatic rst();
    srst_in = 1'b1;
    repeat (8) @(negedge clock_in);
    srst_in = 1'b0;
    m = '{default: 8'h00};
    m[4] = 8'h3F;
    m[5] = 8'h3F;
    m[33] = 8'h30;
    {mp, mo, mc, ov} = '0;
  endtask
  task automatic sp(input logic [7:0] v, input logic [1:0] e);
    w(13'h109, v);
    for (int i = 0; i < 2; i++) begin
      @(negedge clock_in);
      sync_evt_in = 1'b1;
      @(negedge clock_in);
      sync_evt_in = 1'b0;
      chk(so, e[i]);
    end
  endtask
  initial begin
    logic [7:0] d;
    logic [12:0] a;
    rst();
    rdall();
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      d[6:4] = k[2:0];
      w(13'h021, d);
      w(13'h019 + 13'(k % 4), 8'($random(seed)));
      chk_out();
    end
    for (int i = 0; i < 5; i++) begin
      d = (8'h03 << i) | (8'($random(seed)) & 8'h30);
      w(13'h004, d);
      w(13'h005, d);
      w(13'h022, 8'($random(seed)));
      rdall();
    end
    w(13'h100, 8'($random(seed)) | 8'h40);
    chk_out();
    w(13'h0FF, 8'h00);
    chk_out();
    w(13'h0FF, 8'h01);
    chk_out();
    repeat (60) begin
      a = al[{$random(seed)} % 14];
      d = 8'($random(seed));
      if (a == 13'h004 || a == 13'h005) begin
        d = d & 8'h3F;
        w(13'h004, d);
        a = 13'h005;
      end
      w(a, d);
      rdall();
    end
    sp(8'h03, 2'h1);
    sp(8'h01, 2'h3);
    sp(8'h00, 2'h0);
    sp(8'h02, 2'h0);
    sp(8'h03, 2'h1);
    rst();
    rdall();
    print_verdict();
  end
  initial begin
    #40000;
    err_count++;
    print_verdict();
  end
endmodule
